// ==== pkg/rcf_pkg.sv ====
// Package: register map, field positions and codes of the reset-cause and ALU flag bank
package rcf_pkg;
    // Register offsets
    localparam logic [7:0] RCF_OFF_RESET_CAUSE = 8'h8E;
    localparam logic [7:0] RCF_OFF_ALU_FLAGS   = 8'h03;
    localparam logic [7:0] RCF_OFF_IRQ_STATUS  = 8'h90;
    localparam logic [7:0] RCF_OFF_IRQ_MASK    = 8'h91;
    // Reset-cause fields
    localparam int RCF_BIT_UNDERVOLT = 0;
    localparam int RCF_BIT_POWERUP   = 1;
    // ALU and power flag fields
    localparam int RCF_BIT_CARRY     = 0;
    localparam int RCF_BIT_NIBBLE    = 1;
    localparam int RCF_BIT_ZERO      = 2;
    localparam int RCF_BIT_SLEEP     = 3;
    localparam int RCF_BIT_WATCHDOG  = 4;
    localparam int RCF_BIT_BANK0     = 5;
    // Interrupt status fields
    localparam int RCF_IRQ_POR       = 0;
    localparam int RCF_IRQ_BROWNOUT  = 1;
    localparam int RCF_IRQ_WATCHDOG  = 2;
    localparam int RCF_IRQ_PIN       = 3;
    localparam int RCF_IRQ_W         = 4;
    // Reset values
    localparam logic [7:0] RCF_ALU_RST   = 8'h18;
    localparam logic [1:0] RCF_CAUSE_RST = 2'h0;
    // Reset sources
    typedef enum logic [2:0] {
        RCF_RST_NONE = 3'b000,
        RCF_RST_POR  = 3'b001,
        RCF_RST_BROWNOUT = 3'b010,
        RCF_RST_WATCHDOG = 3'b011,
        RCF_RST_PIN  = 3'b100
    } rcf_rst_t;
    // ALU operations
    typedef enum logic [2:0] {
        RCF_OP_NONE  = 3'b000,
        RCF_OP_ADD   = 3'b001,
        RCF_OP_SUB   = 3'b010,
        RCF_OP_LOGIC = 3'b011,
        RCF_OP_ROTR  = 3'b100,
        RCF_OP_ROTL  = 3'b101
    } rcf_op_t;
endpackage : rcf_pkg

// ==== pkg/rcf_alu_if.sv ====
// Interface: operands and computed flags between the bank and its flag unit
`timescale 1ns/10ps
interface rcf_alu_if;
    import rcf_pkg::*;
    rcf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       carry_in;
    logic [7:0] result;
    logic       carry;
    logic       nibble;
    logic       zero;
    modport bank (output op, a, b, carry_in, input result, carry, nibble, zero);
    modport unit (input op, a, b, carry_in, output result, carry, nibble, zero);
endinterface : rcf_alu_if

// ==== hdl/rcf_flag_unit.sv ====
// Flag unit: result and carry, nibble and zero flags for one operation
`timescale 1ns/10ps
module rcf_flag_unit (
    rcf_alu_if.unit alu
);
    import rcf_pkg::*;
    logic [8:0] sum;
    logic [4:0] low;
    always_comb begin
        sum        = 9'h000;
        low        = 5'h00;
        alu.result = 8'h00;
        alu.carry  = alu.carry_in;
        alu.nibble = 1'b0;
        case (alu.op)
            RCF_OP_ADD: begin
                sum        = {1'b0, alu.a} + {1'b0, alu.b};
                low        = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
                alu.result = sum[7:0];
                alu.carry  = sum[8];
                alu.nibble = low[4];
            end
            RCF_OP_SUB: begin
                sum        = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
                low        = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
                alu.result = sum[7:0];
                alu.carry  = sum[8];
                alu.nibble = low[4];
            end
            RCF_OP_LOGIC: begin
                alu.result = alu.a & alu.b;
            end
            RCF_OP_ROTR: begin
                alu.result = {alu.carry_in, alu.a[7:1]};
                alu.carry  = alu.a[0];
            end
            RCF_OP_ROTL: begin
                alu.result = {alu.a[6:0], alu.carry_in};
                alu.carry  = alu.a[7];
            end
            default: begin
                alu.result = 8'h00;
            end
        endcase
        alu.zero = (alu.result == 8'h00);
    end
endmodule : rcf_flag_unit

// ==== hdl/rcf_bank.sv ====
// Reset-cause, ALU and power flag register bank with interrupt
// Summary of operation
// - Interrupt status flags tell power-on, brown-out, watchdog, pin apart
// - Power-on reset clears power-up flag
// - Brown-out reset clears undervoltage flag
// - Undervoltage flag undefined after power-on reset
// - Undervoltage flag don't-care when detector disabled
// - Reset-cause bits seven to two read zero
// - Addition carry from result top bit
// - Subtract adds two's complement, carry inverted borrow
// - Rotates load carry with shifted-out bit
// - Carry and nibble flags are inverted borrows in subtract
// - Computed flags override writes to those bits
// - Watchdog and sleep flags ignore software writes
`timescale 1ns/10ps
module rcf_bank (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // Reset and power events
    input  wire rcf_pkg::rcf_rst_t  reset_event,
    input  wire logic               undervoltage_detect_enable,
    input  wire logic               watchdog_kick_instruction,
    input  wire logic               sleep_instruction,
    // ALU operation
    input  wire rcf_pkg::rcf_op_t   alu_op,
    input  wire logic [7:0]         alu_a,
    input  wire logic [7:0]         alu_b,
    input  wire logic               alu_to_flags_reg,
    output logic      [7:0]         alu_result,
    // Flags and interrupt
    output logic      [7:0]         alu_and_power_flags,
    output logic      [7:0]         reset_cause_flags,
    output logic                    irq
);
    import rcf_pkg::*;

    logic [7:0]          flags_r, flags_nxt;
    logic [1:0]          cause_r, cause_nxt;
    logic [RCF_IRQ_W-1:0] stat_r, stat_nxt;
    logic [RCF_IRQ_W-1:0] mask_r, mask_nxt;
    logic [7:0]          rdata_r, rdata_nxt;
    logic [7:0]          res_r, res_nxt;
    logic                irq_r, irq_nxt;
    logic [RCF_IRQ_W-1:0] ev;
    logic                wr_flags, wr_cause, wr_stat, wr_mask;

    rcf_alu_if alu ();

    assign alu.op       = alu_op;
    assign alu.a        = alu_a;
    assign alu.b        = alu_b;
    assign alu.carry_in = flags_r[RCF_BIT_CARRY];

    rcf_flag_unit u_flag (
        .alu (alu.unit)
    );

    // Register write decode
    always_comb begin
        wr_flags = 1'b0;
        wr_cause = 1'b0;
        wr_stat  = 1'b0;
        wr_mask  = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                RCF_OFF_ALU_FLAGS:   wr_flags = 1'b1;
                RCF_OFF_RESET_CAUSE: wr_cause = 1'b1;
                RCF_OFF_IRQ_STATUS:  wr_stat  = 1'b1;
                RCF_OFF_IRQ_MASK:    wr_mask  = 1'b1;
                default:             wr_flags = 1'b0;
            endcase
        end
    end

    // Reset-cause events
    always_comb begin
        ev = '0;
        case (reset_event)
            RCF_RST_POR: begin
                ev[RCF_IRQ_POR] = 1'b1;
            end
            RCF_RST_BROWNOUT: begin
                ev[RCF_IRQ_BROWNOUT] = 1'b1;
            end
            RCF_RST_WATCHDOG: begin
                ev[RCF_IRQ_WATCHDOG] = 1'b1;
            end
            RCF_RST_PIN: begin
                ev[RCF_IRQ_PIN] = 1'b1;
            end
            default: begin
                ev = '0;
            end
        endcase
    end

    // Flag register next state
    always_comb begin
        flags_nxt = flags_r;
        res_nxt   = res_r;
        if (wr_flags) begin
            // Sleep and watchdog bits keep their value
            flags_nxt[2:0] = reg_wdata[2:0];
            flags_nxt[7:5] = reg_wdata[7:5];
        end
        if (alu_op != RCF_OP_NONE) begin
            res_nxt = alu.result;
            if (alu_to_flags_reg) begin
                flags_nxt[7:5] = alu.result[7:5];
            end
            // Computed flags win over any write
            flags_nxt[RCF_BIT_CARRY]  = alu.carry;
            flags_nxt[RCF_BIT_NIBBLE] = flags_r[RCF_BIT_NIBBLE];
            flags_nxt[RCF_BIT_ZERO]   = flags_r[RCF_BIT_ZERO];
            case (alu_op)
                RCF_OP_ADD, RCF_OP_SUB: begin
                    flags_nxt[RCF_BIT_NIBBLE] = alu.nibble;
                    flags_nxt[RCF_BIT_ZERO]   = alu.zero;
                end
                RCF_OP_LOGIC: begin
                    flags_nxt[RCF_BIT_ZERO] = alu.zero;
                end
                default: begin
                    // Rotates leave the zero flag alone
                    flags_nxt[RCF_BIT_ZERO] = flags_r[RCF_BIT_ZERO];
                end
            endcase
        end
        if (watchdog_kick_instruction) begin
            flags_nxt[RCF_BIT_WATCHDOG] = 1'b1;
            flags_nxt[RCF_BIT_SLEEP]    = 1'b1;
        end else if (sleep_instruction) begin
            flags_nxt[RCF_BIT_WATCHDOG] = 1'b1;
            flags_nxt[RCF_BIT_SLEEP]    = 1'b0;
        end
        case (reset_event)
            RCF_RST_POR: begin
                flags_nxt = RCF_ALU_RST;
            end
            RCF_RST_WATCHDOG: begin
                flags_nxt[RCF_BIT_WATCHDOG] = 1'b0;
            end
            RCF_RST_BROWNOUT, RCF_RST_PIN: begin
                flags_nxt[RCF_BIT_BANK0] = 1'b0;
            end
            default: begin
                flags_nxt = flags_nxt;
            end
        endcase
    end

    // Reset-cause register next state
    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = reg_wdata[1:0];
        end
        case (reset_event)
            RCF_RST_POR: begin
                cause_nxt[RCF_BIT_POWERUP] = 1'b0;
                // Left as held: no defined value on power-on
                cause_nxt[RCF_BIT_UNDERVOLT] = cause_r[RCF_BIT_UNDERVOLT];
            end
            RCF_RST_BROWNOUT: begin
                if (undervoltage_detect_enable) begin
                    cause_nxt[RCF_BIT_UNDERVOLT] = 1'b0;
                end
            end
            default: begin
                cause_nxt = cause_nxt;
            end
        endcase
    end

    // Interrupt status and mask next state
    always_comb begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~reg_wdata[RCF_IRQ_W-1:0];
        end
        // New event wins over a clear
        stat_nxt = stat_nxt | ev;
        if (wr_mask) begin
            mask_nxt = reg_wdata[RCF_IRQ_W-1:0];
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // Read port next state
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                RCF_OFF_RESET_CAUSE: rdata_nxt = {6'h00, cause_r};
                RCF_OFF_ALU_FLAGS:   rdata_nxt = flags_r;
                RCF_OFF_IRQ_STATUS:  rdata_nxt = {{(8-RCF_IRQ_W){1'b0}}, stat_r};
                RCF_OFF_IRQ_MASK:    rdata_nxt = {{(8-RCF_IRQ_W){1'b0}}, mask_r};
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // Flag and result registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_r <= RCF_ALU_RST;
            res_r   <= 8'h00;
        end else if (clk_en) begin
            flags_r <= flags_nxt;
            res_r   <= res_nxt;
        end
    end

    // Reset-cause register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cause_r <= RCF_CAUSE_RST;
        end else if (clk_en) begin
            cause_r <= cause_nxt;
        end
    end

    // Interrupt registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stat_r <= '0;
            mask_r <= '0;
            irq_r  <= 1'b0;
        end else if (clk_en) begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata           = rdata_r;
    assign alu_result          = res_r;
    assign alu_and_power_flags = flags_r;
    assign reset_cause_flags   = {6'h00, cause_r};
    assign irq                 = irq_r;
endmodule : rcf_bank

// ==== sim/rcf_bank_assertions.sv ====
// Checker: timing properties on the ports of the flag bank
`timescale 1ns/10ps
module rcf_bank_assertions
    import rcf_pkg::*;
(
    // Clock and reset
    input wire logic     ref_clk,
    input wire logic     sys_rst,
    input wire logic     clk_en,
    // Events
    input wire rcf_rst_t reset_event,
    input wire logic     undervoltage_detect_enable,
    input wire logic     watchdog_kick_instruction,
    input wire logic     sleep_instruction,
    // Operation and flags
    input wire rcf_op_t  alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic [7:0] alu_result,
    input wire logic [7:0] alu_and_power_flags,
    input wire logic [7:0] reset_cause_flags,
    input wire logic     irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire go = clk_en && reset_event == RCF_RST_NONE;
    AST_RSV_ZERO: assert property (reset_cause_flags[7:2] == 6'h00)
        else $error("cause top bits set");
    AST_POR_CLR: assert property (clk_en && reset_event == RCF_RST_POR |=>
        !reset_cause_flags[1] && alu_and_power_flags[4:3] == 2'h3) else $error("power-on flags wrong");
    AST_BROWNOUT_CLR: assert property (clk_en && reset_event == RCF_RST_BROWNOUT && undervoltage_detect_enable |=>
        !reset_cause_flags[0]) else $error("undervoltage flag not cleared");
    AST_WATCHDOG_CLR: assert property (clk_en && reset_event == RCF_RST_WATCHDOG |=>
        !alu_and_power_flags[4]) else $error("watchdog flag not cleared");
    AST_SLEEP: assert property (go && sleep_instruction && !watchdog_kick_instruction |=>
        alu_and_power_flags[4:3] == 2'h2) else $error("sleep flags wrong");
    AST_ADD: assert property (go && alu_op == RCF_OP_ADD |=>
        {alu_and_power_flags[0], alu_result} == {1'b0, $past(alu_a)} + {1'b0, $past(alu_b)})
        else $error("add carry wrong");
    AST_SUB: assert property (go && alu_op == RCF_OP_SUB |=>
        {alu_and_power_flags[0], alu_result} == {1'b0, $past(alu_a)} + {1'b0, ~$past(alu_b)} + 9'h001)
        else $error("subtract borrow wrong");
    AST_ZERO: assert property (go && alu_op inside {RCF_OP_ADD, RCF_OP_SUB, RCF_OP_LOGIC} |=>
        alu_and_power_flags[2] == (alu_result == 8'h00)) else $error("zero flag wrong");
    AST_ROTL: assert property (go && alu_op == RCF_OP_ROTL |=> alu_and_power_flags[0] == $past(alu_a[7])
        && alu_result == {$past(alu_a[6:0]), $past(alu_and_power_flags[0])}) else $error("rotate wrong");
    AST_ROTR: assert property (go && alu_op == RCF_OP_ROTR |=> alu_and_power_flags[0] == $past(alu_a[0])
        && alu_result == {$past(alu_and_power_flags[0]), $past(alu_a[7:1])}) else $error("right rotate wrong");
    cover property (go && alu_op == RCF_OP_ROTR);
    cover property (irq);
    cover property (reset_event == RCF_RST_BROWNOUT && undervoltage_detect_enable);
endmodule : rcf_bank_assertions
bind rcf_bank rcf_bank_assertions i_rcf_bank_assertions (
    .ref_clk                    (ref_clk),
    .sys_rst                    (sys_rst),
    .clk_en                     (clk_en),
    .reset_event                (reset_event),
    .undervoltage_detect_enable (undervoltage_detect_enable),
    .watchdog_kick_instruction  (watchdog_kick_instruction),
    .sleep_instruction          (sleep_instruction),
    .alu_op                     (alu_op),
    .alu_a                      (alu_a),
    .alu_b                      (alu_b),
    .alu_result                 (alu_result),
    .alu_and_power_flags        (alu_and_power_flags),
    .reset_cause_flags          (reset_cause_flags),
    .irq                        (irq)
);

// ==== sim/rcf_bank_tb_top.sv ====
// Testbench: register, event and operation checks of the flag bank
`timescale 1ns/10ps
module rcf_bank_tb_top;
    import rcf_pkg::*;
    logic       ref_clk, sys_rst, clk_en, reg_wr, reg_rd, uv_en, kick, slp, to_flags, irq, rd_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, alu_a, alu_b, alu_result, flags, cause;
    rcf_rst_t   reset_event;
    rcf_op_t    alu_op;
    int         err_total, cmp_count;
    logic [7:0] exp_q[$];
    rcf_bank i_rcf_bank (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reset_event, .undervoltage_detect_enable(uv_en), .watchdog_kick_instruction(kick),
        .sleep_instruction(slp), .alu_op, .alu_a, .alu_b, .alu_to_flags_reg(to_flags), .alu_result,
        .alu_and_power_flags(flags), .reset_cause_flags(cause), .irq);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches %0d of %0d compares", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask : rd
    task automatic ev(input rcf_rst_t e);
        @(posedge ref_clk);
        reset_event <= e;
        @(posedge ref_clk);
        reset_event <= RCF_RST_NONE;
    endtask : ev
    task automatic pw(input logic k);
        @(posedge ref_clk);
        kick <= k;
        slp  <= !k;
        @(posedge ref_clk);
        kick <= 1'b0;
        slp  <= 1'b0;
    endtask : pw
    task automatic alu(input rcf_op_t o, input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        alu_op <= o;
        alu_a  <= a;
        alu_b  <= b;
        @(posedge ref_clk);
        alu_op <= RCF_OP_NONE;
    endtask : alu
    task automatic irq_is(input logic v);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq", {7'h00, irq}, {7'h00, v});
    endtask : irq_is
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Read data stands in the cycle after the strobe
    always @(posedge ref_clk) rd_q <= reg_rd & clk_en & ~sys_rst;
    always @(negedge ref_clk) begin
        if (rd_q) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        {sys_rst, clk_en, uv_en} = 3'h7;
        {reg_wr, reg_rd, kick, slp, to_flags} = 5'h00;
        {reg_addr, reg_wdata, alu_a, alu_b} = 32'h0;
        reset_event = RCF_RST_NONE;
        alu_op = RCF_OP_NONE;
        void'($urandom(7));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(RCF_OFF_RESET_CAUSE, 8'h00);
        rd(RCF_OFF_ALU_FLAGS, 8'h18);
        rd(8'h55, 8'h00);
        wr(RCF_OFF_RESET_CAUSE, 8'hFF);
        rd(RCF_OFF_RESET_CAUSE, 8'h03);
        ev(RCF_RST_BROWNOUT);
        rd(RCF_OFF_RESET_CAUSE, 8'h02);
        wr(RCF_OFF_RESET_CAUSE, 8'h03);
        uv_en <= 1'b0;
        ev(RCF_RST_BROWNOUT);
        rd(RCF_OFF_RESET_CAUSE, 8'h03);
        ev(RCF_RST_POR);
        rd(RCF_OFF_RESET_CAUSE, 8'h01);
        ev(RCF_RST_WATCHDOG);
        ev(RCF_RST_PIN);
        rd(RCF_OFF_RESET_CAUSE, 8'h01);
        chk("reset_cause_flags", cause, 8'h01);
        rd(RCF_OFF_ALU_FLAGS, 8'h08);
        rd(RCF_OFF_IRQ_STATUS, 8'h0F);
        irq_is(1'b0);
        wr(RCF_OFF_IRQ_MASK, 8'h04);
        irq_is(1'b1);
        wr(RCF_OFF_IRQ_STATUS, 8'h04);
        irq_is(1'b0);
        rd(RCF_OFF_IRQ_STATUS, 8'h0B);
        wr(RCF_OFF_ALU_FLAGS, 8'h00);
        rd(RCF_OFF_ALU_FLAGS, 8'h08);
        pw(1'b1);
        rd(RCF_OFF_ALU_FLAGS, 8'h18);
        pw(1'b0);
        rd(RCF_OFF_ALU_FLAGS, 8'h10);
        clk_en <= 1'b0;
        ev(RCF_RST_WATCHDOG);
        clk_en <= 1'b1;
        rd(RCF_OFF_ALU_FLAGS, 8'h10);
        chk("alu_and_power_flags", flags, 8'h10);
        to_flags <= 1'b1;
        fork
            wr(RCF_OFF_ALU_FLAGS, 8'h00);
            alu(RCF_OP_ADD, 8'hFF, 8'h01);
        join
        to_flags <= 1'b0;
        rd(RCF_OFF_ALU_FLAGS, 8'h17);
        alu(RCF_OP_SUB, 8'h05, 8'h07);
        rd(RCF_OFF_ALU_FLAGS, 8'h10);
        chk("alu_result", alu_result, 8'hFE);
        repeat (150) alu(rcf_op_t'(3'($urandom_range(5, 1))), 8'($urandom), 8'($urandom));
        repeat (3) @(posedge ref_clk);
        report_and_stop();
    end
endmodule : rcf_bank_tb_top
